// File: logic/ebsw_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ebsw_cfg.svh"
module ebsw_top #(
    parameter int AD_W = `EBSW_AD_W
) (
    input  wire logic                 clk,
    input  wire logic                 resetn,
    input  wire logic                 req_valid,
    input  wire ebsw_pkg::ebsw_req_t  req,
    input  wire ebsw_pkg::ebsw_cfg_t  chip_config_byte,
    input  wire logic                 bus_ready,
    input  wire logic [15:0]          bus_ad_i,
    output var  logic                 req_ready,
    output var  logic                 done,
    output var  logic [15:0]          rdata,
    output var  logic                 bus_clock_output,
    output var  logic                 addr_latch,
    output var  logic                 read_strobe_n,
    output var  logic                 upper_lane_strobe_n,
    output var  logic                 lower_lane_strobe_n,
    output var  logic [15:0]          bus_ad_o,
    output var  logic [15:0]          bus_ad_oe
);
    import ebsw_pkg::*;

    if (AD_W != `EBSW_AD_W)
    begin : g_chk
        $error("address/data bus must be sixteen lines wide");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset release through two flops.

    logic rst_meta_reg;
    logic rst_n_reg;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_meta_reg <= 1'b0;
            rst_n_reg    <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n_reg    <= rst_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Lane strobe decode for a write, returned as {upper, lower} active low.

    function automatic logic [1:0] lane_strobes(input ebsw_req_t r, input logic style);
        logic up;
        logic lo;
        up = 1'b0;
        lo = 1'b0;
        if (style == `EBSW_STYLE_BHE)
        begin
            up = r.byte_high;
            lo = 1'b1;
        end
        else
        begin
            up = r.bus16 ? r.byte_high : 1'b1;
            lo = r.bus16 ? r.byte_low : 1'b1;
        end
        return {~up, ~lo};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Bus cycle engine; the bus clock is clk divided by two and the engine
    // leaves the address and strobe phases only on the clk edge where the bus clock falls.

    ebsw_state_t       state_reg;
    ebsw_state_t       state_next;
    ebsw_req_t         cur_reg;
    ebsw_req_t         cur_next;
    ebsw_cfg_t         cfg_reg;
    ebsw_cfg_t         cfg_next;
    logic              bclk_reg;
    logic              bclk_next;
    logic              ale_reg;
    logic              ale_next;
    logic              rd_n_reg;
    logic              rd_n_next;
    logic              up_n_reg;
    logic              up_n_next;
    logic              lo_n_reg;
    logic              lo_n_next;
    logic [15:0]       ad_reg;
    logic [15:0]       ad_next;
    logic [15:0]       oe_reg;
    logic [15:0]       oe_next;
    logic [15:0]       rdata_reg;
    logic [15:0]       rdata_next;
    logic              done_reg;
    logic              done_next;
    logic              ready_reg;
    logic              ready_next;
    logic              fall;
    logic              wait_clear;
    logic              wait_inc;
    logic              wait_hit;
    logic [1:0]        wait_count;
    logic [1:0]        strobes;

    assign fall    = bclk_reg;
    assign strobes = lane_strobes(cur_reg, cfg_reg.strobe_style);

    ebsw_wait_ctr #(
        .WAIT_W (`EBSW_WAIT_W)
    ) u_wait (
        .clk      (clk),
        .rst_n    (rst_n_reg),
        .clear    (wait_clear),
        .inc      (wait_inc),
        .limit    (cfg_reg.wait_limit),
        .count    (wait_count),
        .at_limit (wait_hit)
    );

    always_comb
    begin
        state_next = state_reg;
        cur_next   = cur_reg;
        cfg_next   = cfg_reg;
        bclk_next  = ~bclk_reg;
        ale_next   = 1'b0;
        rd_n_next  = `EBSW_STROBE_OFF;
        up_n_next  = `EBSW_STROBE_OFF;
        lo_n_next  = `EBSW_STROBE_OFF;
        ad_next    = ad_reg;
        oe_next    = `EBSW_OE_NONE;
        rdata_next = rdata_reg;
        done_next  = 1'b0;
        ready_next = 1'b0;
        wait_clear = 1'b0;
        wait_inc   = 1'b0;
        unique case (state_reg)
            EBSW_IDLE:
            begin
                ready_next = 1'b1;
                if (req_valid && ready_reg)
                begin
                    cur_next   = req;
                    cfg_next   = chip_config_byte;
                    ready_next = 1'b0;
                    wait_clear = 1'b1;
                    // Internal accesses never touch the pins or look at ready.
                    state_next = req.external ? EBSW_ADDR : EBSW_ENDC;
                    // The address goes out from the take edge, so a bus clock fall
                    // on the very next edge still leaves one cycle of address latch.
                    if (req.external)
                    begin
                        ale_next = 1'b1;
                        ad_next  = req.addr;
                        oe_next  = `EBSW_OE_ALL;
                    end
                end
            end
            EBSW_ADDR:
            begin
                ale_next = 1'b1;
                ad_next  = cur_reg.addr;
                oe_next  = `EBSW_OE_ALL;
                if (fall)
                begin
                    ale_next   = 1'b0;
                    state_next = EBSW_STRB;
                end
            end
            EBSW_STRB:
            begin
                // Line 15 and the upper byte stay address on a narrow bus.
                if (cur_reg.bus16)
                begin
                    ad_next = cur_reg.wdata;
                    oe_next = cur_reg.write ? `EBSW_OE_ALL : `EBSW_OE_NONE;
                end
                else
                begin
                    ad_next = {cur_reg.addr[`EBSW_AD_TOP:`EBSW_AD_HI_LSB],
                               cur_reg.wdata[`EBSW_AD_LO_MSB:0]};
                    oe_next = cur_reg.write ? `EBSW_OE_ALL : `EBSW_OE_HIGH;
                end
                if (cur_reg.write)
                begin
                    {up_n_next, lo_n_next} = strobes;
                end
                else
                begin
                    rd_n_next = `EBSW_STROBE_ON;
                end
                if (fall)
                begin
                    if (bus_ready || wait_hit)
                    begin
                        state_next = EBSW_ENDC;
                        up_n_next  = `EBSW_STROBE_OFF;
                        lo_n_next  = `EBSW_STROBE_OFF;
                        rd_n_next  = `EBSW_STROBE_OFF;
                        if (!cur_reg.write)
                        begin
                            rdata_next = bus_ad_i;
                        end
                    end
                    else
                    begin
                        wait_inc = 1'b1;
                    end
                end
            end
            EBSW_ENDC:
            begin
                done_next  = 1'b1;
                ready_next = 1'b1;
                state_next = EBSW_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            state_reg <= EBSW_IDLE;
            cur_reg   <= '0;
            cfg_reg   <= '0;
            bclk_reg  <= 1'b0;
            ale_reg   <= 1'b0;
            rd_n_reg  <= `EBSW_STROBE_OFF;
            up_n_reg  <= `EBSW_STROBE_OFF;
            lo_n_reg  <= `EBSW_STROBE_OFF;
            ad_reg    <= `EBSW_WORD_ZERO;
            oe_reg    <= `EBSW_OE_NONE;
            rdata_reg <= `EBSW_WORD_ZERO;
            done_reg  <= 1'b0;
            ready_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cur_reg   <= cur_next;
            cfg_reg   <= cfg_next;
            bclk_reg  <= bclk_next;
            ale_reg   <= ale_next;
            rd_n_reg  <= rd_n_next;
            up_n_reg  <= up_n_next;
            lo_n_reg  <= lo_n_next;
            ad_reg    <= ad_next;
            oe_reg    <= oe_next;
            rdata_reg <= rdata_next;
            done_reg  <= done_next;
            ready_reg <= ready_next;
        end
    end

    assign req_ready           = ready_reg;
    assign done                = done_reg;
    assign rdata               = rdata_reg;
    assign bus_clock_output    = bclk_reg;
    assign addr_latch          = ale_reg;
    assign read_strobe_n       = rd_n_reg;
    assign upper_lane_strobe_n = up_n_reg;
    assign lower_lane_strobe_n = lo_n_reg;
    assign bus_ad_o            = ad_reg;
    assign bus_ad_oe           = oe_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    bhe_style_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
        (state_reg == EBSW_STRB && $past(state_reg) == EBSW_STRB && cur_reg.write
         && cfg_reg.strobe_style && cur_reg.byte_high) |-> !upper_lane_strobe_n)
        else $error("byte high enable missing on a high write");

    wrh_style_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
        (state_reg == EBSW_STRB && $past(state_reg) == EBSW_STRB && cur_reg.write
         && !cfg_reg.strobe_style) |-> (upper_lane_strobe_n == (cur_reg.bus16 && !cur_reg.byte_high)))
        else $error("write high strobe wrong");

    wrl_style_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
        (state_reg == EBSW_STRB && $past(state_reg) == EBSW_STRB && cur_reg.write
         && !cfg_reg.strobe_style) |-> (lower_lane_strobe_n == (cur_reg.bus16 && !cur_reg.byte_low)))
        else $error("write low strobe wrong");

    wait_insert_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
        (state_reg == EBSW_STRB && fall && !bus_ready && !wait_hit)
        |=> state_reg == EBSW_STRB ##1 state_reg == EBSW_STRB)
        else $error("wait state not inserted");

    wait_limit_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
        (state_reg == EBSW_STRB && fall && wait_hit) |=> state_reg == EBSW_ENDC ##1 done)
        else $error("wait limit not honoured");

    ready_fast_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
        (state_reg == EBSW_ADDR && fall) ##2 (bclk_reg && bus_ready) |=> state_reg == EBSW_ENDC)
        else $error("ready high still stretched the cycle");

    internal_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
        (state_reg == EBSW_IDLE && req_valid && req_ready && !req.external)
        |=> (state_reg == EBSW_ENDC && !addr_latch) ##1 done)
        else $error("internal access went to the bus");

    line15_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
        (state_reg == EBSW_STRB && $past(state_reg) == EBSW_STRB && !cur_reg.bus16)
        |-> (bus_ad_oe[`EBSW_AD_TOP] && bus_ad_o[`EBSW_AD_TOP] == cur_reg.addr[`EBSW_AD_TOP]))
        else $error("line 15 not held as address on narrow bus");

    wait_range_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
        (state_reg != EBSW_IDLE) |-> wait_count <= cfg_reg.wait_limit)
        else $error("wait count passed the limit");
endmodule
`default_nettype wire

// File: common/ebsw_cfg.svh
`ifndef EBSW_CFG_SVH
`define EBSW_CFG_SVH

// Strobe style select values carried by the chip configuration byte.
`define EBSW_STYLE_BHE     1'b1
`define EBSW_STYLE_WRH     1'b0
// Idle (negated) level of every active-low strobe.
`define EBSW_STROBE_OFF    1'b1
`define EBSW_STROBE_ON     1'b0
// Width of the wait-state limit field.
`define EBSW_WAIT_W        2
`define EBSW_WAIT_ZERO     2'h0
`define EBSW_WAIT_ONE      2'h1
// Address/data bus width and the byte split.
`define EBSW_AD_W          16
`define EBSW_AD_LO_MSB     7
`define EBSW_AD_HI_LSB     8
`define EBSW_AD_TOP        15
`define EBSW_WORD_ZERO     16'h0000
`define EBSW_OE_ALL        16'hFFFF
`define EBSW_OE_HIGH       16'hFF00
`define EBSW_OE_NONE       16'h0000

`endif

// File: common/ebsw_pkg.sv
`default_nettype none
package ebsw_pkg;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        write;
        logic        byte_high;
        logic        byte_low;
        logic        bus16;
        logic        external;
    } ebsw_req_t;

    typedef struct packed {
        logic       strobe_style;
        logic [1:0] wait_limit;
    } ebsw_cfg_t;

    typedef enum logic [1:0] {
        EBSW_IDLE = 2'b00,
        EBSW_ADDR = 2'b01,
        EBSW_STRB = 2'b11,
        EBSW_ENDC = 2'b10
    } ebsw_state_t;

endpackage
`default_nettype wire

// File: logic/ebsw_wait_ctr.sv
`timescale 1ns/1ps
`default_nettype none
`include "ebsw_cfg.svh"
module ebsw_wait_ctr #(
    parameter int WAIT_W = `EBSW_WAIT_W
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              clear,
    input  wire logic              inc,
    input  wire logic [WAIT_W-1:0] limit,
    output var  logic [WAIT_W-1:0] count,
    output var  logic              at_limit
);
    logic [WAIT_W-1:0] count_reg;
    logic [WAIT_W-1:0] count_next;

    if (WAIT_W < 1)
    begin : g_chk
        $error("wait counter width must be at least one");
    end

    // Unsigned limit; zero means no wait state is ever inserted.
    always_comb
    begin
        count_next = count_reg;
        if (clear)
        begin
            count_next = '0;
        end
        else if (inc && (count_reg != limit))
        begin
            count_next = count_reg + WAIT_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_reg <= '0;
        end
        else
        begin
            count_reg <= count_next;
        end
    end

    assign count    = count_reg;
    assign at_limit = (count_reg == limit);
endmodule
`default_nettype wire

// File: tb/ebsw_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module ebsw_mem_model (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        bus_clock_output,
    input  wire logic        read_strobe_n,
    input  wire logic        upper_lane_strobe_n,
    input  wire logic        lower_lane_strobe_n,
    input  wire logic [7:0]  waits,
    input  wire logic        hold_low,
    input  wire logic [15:0] rd_word,
    output var  logic        bus_ready,
    output var  logic [15:0] bus_ad_i
);
    logic        act;
    logic [7:0]  cnt_reg;
    logic [15:0] last_reg;

    assign act = (read_strobe_n & upper_lane_strobe_n & lower_lane_strobe_n) == 1'b0;
    // A slow party holds ready low for a set number of falls, or for good when hold_low is set.
    assign bus_ready = !(hold_low || (act && cnt_reg < waits));
    // Released lines toggle every cycle so that a stale capture can never pass as a match.
    assign bus_ad_i = read_strobe_n ? ~last_reg : rd_word;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cnt_reg  <= 8'h00;
            last_reg <= 16'h0000;
        end
        else
        begin
            if (!act)
                cnt_reg <= 8'h00;
            else if (bus_clock_output)
                cnt_reg <= cnt_reg + 8'h01;
            last_reg <= bus_ad_i;
        end
    end
endmodule
`default_nettype wire

// File: tb/ebsw_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module ebsw_top_test;
    import ebsw_pkg::*;
    localparam int INT_LAT = 2;
    localparam int LIMIT   = 5000;
    logic        clk;
    logic        resetn;
    logic        req_valid;
    ebsw_req_t   req;
    ebsw_cfg_t   cfg;
    logic        bus_ready;
    logic [15:0] bus_ad_i;
    logic        req_ready;
    logic        done;
    logic [15:0] rdata;
    logic        bclk;
    logic        read_n;
    logic        upper_n;
    logic        lower_n;
    logic [15:0] ad_o;
    logic [15:0] ad_oe;
    logic [7:0]  waits;
    logic        hold_low;
    logic [15:0] rd_word;
    int          fails;
    int          tests_run;
    int          cycles;
    int          lowc;
    int          lat;
    logic        up;
    logic        lo;
    logic [1:0]  l15;
    logic        ale;
    logic [15:0] dat;
    logic [15:0] adr;
    int          alec;

    ebsw_top uut (.clk(clk), .resetn(resetn), .req_valid(req_valid), .req(req), .chip_config_byte(cfg),
        .bus_ready(bus_ready), .bus_ad_i(bus_ad_i), .req_ready(req_ready), .done(done), .rdata(rdata),
        .bus_clock_output(bclk), .addr_latch(ale), .read_strobe_n(read_n), .upper_lane_strobe_n(upper_n),
        .lower_lane_strobe_n(lower_n), .bus_ad_o(ad_o), .bus_ad_oe(ad_oe));
    ebsw_mem_model mem (.clk(clk), .resetn(resetn), .bus_clock_output(bclk), .read_strobe_n(read_n),
        .upper_lane_strobe_n(upper_n), .lower_lane_strobe_n(lower_n), .waits(waits), .hold_low(hold_low),
        .rd_word(rd_word), .bus_ready(bus_ready), .bus_ad_i(bus_ad_i));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("tests_run=%0d fails=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic ebsw_req_t mk(input logic wr, input logic bh, input logic bl, input logic b16,
                                     input logic ext);
        return '{addr: 16'h8A5C, wdata: 16'h3C96, write: wr, byte_high: bh, byte_low: bl, bus16: b16,
                 external: ext};
    endfunction

    // Holds the request until taken, then watches the strobe phase up to the done pulse.
    task automatic run(input ebsw_req_t r, input ebsw_cfg_t c, input logic [7:0] w, input logic h);
        lowc = 0;
        lat = 0;
        alec = 0;
        adr = 16'h0000;
        @(posedge clk);
        req_valid <= 1'b1;
        req <= r;
        cfg <= c;
        waits <= w;
        hold_low <= h;
        @(posedge clk);
        while (req_ready !== 1'b1)
            @(posedge clk);
        req_valid <= 1'b0;
        do
        begin
            @(posedge clk);
            lat++;
            if (ale === 1'b1)
            begin
                alec++;
                adr = ad_o;
            end
            if ((read_n & upper_n & lower_n) !== 1'b1)
            begin
                if (lowc == 0)
                begin
                    up = upper_n;
                    lo = lower_n;
                    l15 = {ad_oe[15], ad_o[15]};
                    dat = ad_o;
                end
                lowc++;
            end
        end
        while (done !== 1'b1);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_internal;
        run(mk(1'b1, 1'b1, 1'b1, 1'b1, 1'b0), 3'h7, 8'h00, 1'b1);
        chk(lat, INT_LAT);
        chk(lowc, 0);
        chk(alec, 0);
        $display("test internal done");
    endtask

    task automatic t_b2b;
        @(posedge clk);
        req_valid <= 1'b1;
        req <= mk(1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
        @(posedge clk);
        while (req_ready !== 1'b1)
            @(posedge clk);
        for (int k = 1; k <= 4; k++)
        begin
            @(posedge clk);
            chk(done, (k % 2) == 0);
            if (k == 2)
                req_valid <= 1'b0;
        end
        $display("test back_to_back done");
    endtask

    task automatic t_strobes;
        ebsw_req_t r;
        for (int s = 0; s < 2; s++)
            for (int b = 0; b < 2; b++)
                for (int m = 1; m < 4; m++)
                begin
                    r = mk(1'b1, m[1], m[0], b[0], 1'b1);
                    run(r, {s[0], 2'h0}, 8'h00, 1'b0);
                    chk(up, !(m[1] | (!s[0] & !b[0])));
                    chk(lo, !(s[0] | !b[0] | m[0]));
                    chk(lowc, 1);
                    chk(adr, 16'h8A5C);
                    chk(dat, b[0] ? 16'h3C96 : 16'h8A96);
                    if (b == 0)
                        chk(l15, 2'b11);
                    else if (m == 3)
                        chk(l15, 2'b10);
                end
        $display("test strobes done");
    endtask

    task automatic t_waits;
        for (int lim = 0; lim < 4; lim++)
        begin
            run(mk(1'b1, 1'b1, 1'b1, 1'b1, 1'b1), {1'b1, lim[1:0]}, 8'h00, 1'b1);
            chk(lowc, 1 + 2 * lim);
        end
        run(mk(1'b1, 1'b1, 1'b1, 1'b0, 1'b1), 3'h7, 8'h01, 1'b0);
        chk(lowc, 3);
        $display("test waits done");
    endtask

    task automatic t_read;
        rd_word <= 16'hC3A5;
        run(mk(1'b0, 1'b1, 1'b1, 1'b1, 1'b1), 3'h3, 8'h02, 1'b0);
        chk(rdata, 16'hC3A5);
        chk(lowc, 5);
        $display("test read done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            fails++;
            end_sim;
        end
    end

    initial
    begin
        resetn = 1'b0;
        req_valid = 1'b0;
        req = '0;
        cfg = '0;
        waits = 8'h00;
        hold_low = 1'b0;
        rd_word = 16'h0000;
        fails = 0;
        tests_run = 0;
        cycles = 0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        t_internal;
        t_b2b;
        t_strobes;
        t_waits;
        t_read;
        end_sim;
    end
endmodule
`default_nettype wire
